// ==== core/lpmc_pkg.sv ====
// lpmc_pkg: constants, register map and state types of the low-power mode controller.
// assumes a 10 MHz system clock and an APB slave with 32-bit data.
package lpmc_pkg;
	// register byte offsets
	localparam logic [7:0] LPMC_OFS_CTRL = 8'h00;
	localparam logic [7:0] LPMC_OFS_CLKCFG = 8'h04;
	localparam logic [7:0] LPMC_OFS_STATUS = 8'h08;
	localparam logic [7:0] LPMC_OFS_CAUSE = 8'h0c;
	localparam logic [7:0] LPMC_OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] LPMC_OFS_IRQ_CLR = 8'h14;
	localparam logic [7:0] LPMC_OFS_IRQ_EN = 8'h18;
	// values after reset
	localparam logic [1:0] LPMC_VRANGE_RST = 2'h2;
	localparam logic [15:0] LPMC_REQ_KHZ_RST = 16'h0fa0;
	// low-power mode selections
	localparam logic [2:0] LPMC_MODE_SLEEP = 3'h0;
	localparam logic [2:0] LPMC_MODE_LPSLEEP = 3'h1;
	localparam logic [2:0] LPMC_MODE_STOP_RTC = 3'h2;
	localparam logic [2:0] LPMC_MODE_STOP_NORTC = 3'h3;
	localparam logic [2:0] LPMC_MODE_STBY_RTC = 3'h4;
	localparam logic [2:0] LPMC_MODE_STBY_NORTC = 3'h5;
	// system clock sources
	localparam logic [1:0] LPMC_CLK_MSI = 2'h0;
	localparam logic [1:0] LPMC_CLK_FAST_INT = 2'h1;
	localparam logic [1:0] LPMC_CLK_FAST_EXT = 2'h2;
	localparam logic [1:0] LPMC_CLK_PLL = 2'h3;
	// frequency caps in kHz
	localparam logic [15:0] LPMC_CAP_R1_KHZ = 16'd32000;
	localparam logic [15:0] LPMC_CAP_R2_KHZ = 16'd16000;
	localparam logic [15:0] LPMC_CAP_R3_KHZ = 16'd4000;
	localparam logic [15:0] LPMC_CAP_LPRUN_KHZ = 16'd131;
	localparam logic [2:0] LPMC_LPRUN_MSI_MAX = 3'h1;
	// timing
	localparam int LPMC_CLK_PERIOD_NS = 100;
	localparam int LPMC_STOP_EXIT_NS = 8000;
	localparam int LPMC_STBY_EXIT_NS = 60000;
	localparam int LPMC_STOP_EXIT_CYC = (LPMC_STOP_EXIT_NS / LPMC_CLK_PERIOD_NS < 1) ? 1 :
		LPMC_STOP_EXIT_NS / LPMC_CLK_PERIOD_NS;
	localparam int LPMC_STBY_EXIT_CYC = (LPMC_STBY_EXIT_NS / LPMC_CLK_PERIOD_NS < 1) ? 1 :
		LPMC_STBY_EXIT_NS / LPMC_CLK_PERIOD_NS;
	localparam logic [9:0] LPMC_STOP_WAIT = 10'(LPMC_STOP_EXIT_CYC - 2);
	localparam logic [9:0] LPMC_STBY_WAIT = 10'(LPMC_STBY_EXIT_CYC - 2);
	// wake cause bits
	localparam int LPMC_WC_PERIPH = 0;
	localparam int LPMC_WC_EXTERNAL_INTERRUPT_LINE = 1;
	localparam int LPMC_WC_PVD = 2;
	localparam int LPMC_WC_COMP = 3;
	localparam int LPMC_WC_USB = 4;
	localparam int LPMC_WC_RTC = 5;
	localparam int LPMC_WC_RSTPIN = 6;
	localparam int LPMC_WC_WDG = 7;
	localparam int LPMC_WC_WKPIN = 8;
	// interrupt status bits
	localparam int LPMC_IRQ_WAKE = 0;
	localparam int LPMC_IRQ_STBY = 1;
	localparam int LPMC_IRQ_CLAMP = 2;

	typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_LPSLEEP, ST_STOP, ST_STANDBY, ST_WAKE} lpmc_state_e;

	typedef struct packed {
		lpmc_state_e state;
		logic [9:0] cnt;
		logic stby_path;
		logic core_reset;
		logic [1:0] vrange;
		logic [2:0] mode_sel;
		logic lprun_req;
		logic slow_int_en;
		logic slow_ext_en;
		logic [1:0] clk_sel;
		logic [2:0] msi_range;
		logic pll_en;
		logic fast_int_en;
		logic fast_ext_en;
		logic [15:0] req_khz;
		logic [8:0] cause;
		logic [2:0] irq_stat;
		logic [2:0] irq_en;
		logic [2:0] wpin_prev;
		logic [31:0] prdata;
	} lpmc_regs_s;
endpackage : lpmc_pkg

// ==== core/lpmc_top.sv ====
// lpmc_top: low-power mode controller with APB registers and one interrupt line.
// assumes all inputs synchronous to i_sys_clk; sleep request is a one-cycle pulse.
// Functional notes
// - three voltage ranges cap cpu clock at 32, 16 and 4 MHz
// - in range three the system clock comes only from the multi-speed oscillator
// - sleep halts only the cpu clock; any peripheral interrupt wakes it
// - low-power run needs multi-speed oscillator range 0/1, 131 kHz, regulator low-power
// - low-power sleep is sleep with low-power regulator; wake returns to full run
// - stop with rtc: core clocks and fast oscillators off, one slow oscillator runs
// - stop ends within 8 us on any valid external interrupt line source
// - stop without rtc stops every oscillator; rtc events cannot wake
// - standby switches regulator off; slow oscillator only in rtc variant
// - standby loses core state except wakeup logic and reset cause
// - standby with rtc exits within 60 us on pin, watchdog or rtc events
// - stop and standby with rtc do not halt rtc, watchdog or their clocks
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module lpmc_top (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// processor and wakeup sources
	input wire logic i_sleep_req,
	input wire logic i_periph_irq,
	input wire logic [15:0] i_external_interrupt_line,
	input wire logic i_programmable_voltage_detector,
	input wire logic i_comp1_event,
	input wire logic i_comp2_event,
	input wire logic i_vref_on,
	input wire logic i_usb_wakeup,
	input wire logic i_rtc_alarm_a,
	input wire logic i_rtc_alarm_b,
	input wire logic i_rtc_tamper,
	input wire logic i_rtc_timestamp,
	input wire logic i_rtc_wakeup,
	input wire logic i_reset_pin_n,
	input wire logic i_independent_watchdog_reset,
	input wire logic [2:0] i_wakeup_pin,
	// power and clock controls
	output logic o_cpu_clk_en,
	output logic o_periph_clk_en,
	output logic o_pll_en,
	output logic o_multi_speed_internal_osc_en,
	output logic o_fast_internal_osc_en,
	output logic o_fast_external_crystal_en,
	output logic o_slow_internal_osc_en,
	output logic o_slow_external_crystal_en,
	output logic o_reg_lowpower,
	output logic o_reg_off,
	output logic o_core_reset,
	output logic [1:0] o_sysclk_sel,
	output logic [15:0] o_cpu_freq_khz,
	output logic o_lprun_active,
	// interrupt
	output logic o_irq
);
	import lpmc_pkg::*;

	lpmc_regs_s r;
	lpmc_regs_s nxt;

	logic [15:0] cap_khz;
	logic lprun_ok;
	logic [8:0] src;
	logic wake_sleep;
	logic wake_stop;
	logic wake_stby;
	logic [2:0] wpin_rise;
	logic acc;
	logic setup;
	logic addr_ok;
	logic rtc_mode;

	// effective clock source and caps
	always_comb begin
		o_sysclk_sel = (r.vrange == 2'h3) ? LPMC_CLK_MSI : r.clk_sel;
		lprun_ok = r.lprun_req && (o_sysclk_sel == LPMC_CLK_MSI) && (r.msi_range <= LPMC_LPRUN_MSI_MAX);
		case (r.vrange)
			2'h2: cap_khz = LPMC_CAP_R2_KHZ;
			2'h3: cap_khz = LPMC_CAP_R3_KHZ;
			default: cap_khz = LPMC_CAP_R1_KHZ;
		endcase
		if (lprun_ok) begin
			cap_khz = LPMC_CAP_LPRUN_KHZ;
		end
		o_cpu_freq_khz = (r.req_khz > cap_khz) ? cap_khz : r.req_khz;
		o_lprun_active = lprun_ok && (r.state == ST_RUN);
	end

	// wakeup source decode
	always_comb begin
		rtc_mode = (r.mode_sel == LPMC_MODE_STOP_RTC) || (r.mode_sel == LPMC_MODE_STBY_RTC);
		wpin_rise = i_wakeup_pin & ~r.wpin_prev;
		src = '0;
		src[LPMC_WC_PERIPH] = i_periph_irq;
		src[LPMC_WC_EXTERNAL_INTERRUPT_LINE] = |i_external_interrupt_line;
		src[LPMC_WC_PVD] = i_programmable_voltage_detector;
		// comparators count only with the internal reference on
		src[LPMC_WC_COMP] = i_vref_on && (i_comp1_event || i_comp2_event);
		src[LPMC_WC_USB] = i_usb_wakeup;
		src[LPMC_WC_RTC] = i_rtc_alarm_a || i_rtc_alarm_b || i_rtc_tamper || i_rtc_timestamp || i_rtc_wakeup;
		src[LPMC_WC_RSTPIN] = !i_reset_pin_n;
		src[LPMC_WC_WDG] = i_independent_watchdog_reset;
		src[LPMC_WC_WKPIN] = |wpin_rise;
		// peripheral, line, pvd, comparator, usb and rtc events wake sleep; reset pin, wakeup pins and watchdog do not
		wake_sleep = |src[LPMC_WC_RTC:LPMC_WC_PERIPH];
		wake_stop = |src[LPMC_WC_USB:LPMC_WC_EXTERNAL_INTERRUPT_LINE] || (rtc_mode && src[LPMC_WC_RTC]);
		wake_stby = src[LPMC_WC_RSTPIN] || src[LPMC_WC_WKPIN] ||
			(rtc_mode && (src[LPMC_WC_WDG] || src[LPMC_WC_RTC]));
	end

	// apb decode; zero wait states
	always_comb begin
		setup = i_psel && !i_penable;
		acc = i_psel && i_penable;
		case (i_paddr)
			LPMC_OFS_CTRL, LPMC_OFS_CLKCFG, LPMC_OFS_STATUS, LPMC_OFS_CAUSE,
			LPMC_OFS_IRQ_STAT, LPMC_OFS_IRQ_CLR, LPMC_OFS_IRQ_EN: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
		o_pready = 1'b1;
		o_pslverr = acc && !addr_ok;
		o_prdata = r.prdata;
		o_irq = |(r.irq_stat & r.irq_en);
	end

	// power and clock gating per state
	always_comb begin
		o_cpu_clk_en = 1'b0;
		o_periph_clk_en = 1'b0;
		o_pll_en = 1'b0;
		o_multi_speed_internal_osc_en = 1'b0;
		o_fast_internal_osc_en = 1'b0;
		o_fast_external_crystal_en = 1'b0;
		o_reg_lowpower = 1'b0;
		o_reg_off = 1'b0;
		// in stop and standby, slow oscillators follow software only in rtc variants
		o_slow_internal_osc_en = r.slow_int_en && rtc_mode;
		o_slow_external_crystal_en = r.slow_ext_en && rtc_mode;
		case (r.state)
			ST_RUN, ST_SLEEP, ST_LPSLEEP: begin
				o_cpu_clk_en = (r.state == ST_RUN);
				o_periph_clk_en = 1'b1;
				o_multi_speed_internal_osc_en = 1'b1;
				o_pll_en = r.pll_en && (r.vrange != 2'h3) && !lprun_ok;
				o_fast_internal_osc_en = r.fast_int_en && (r.vrange != 2'h3) && !lprun_ok;
				o_fast_external_crystal_en = r.fast_ext_en && (r.vrange != 2'h3) && !lprun_ok;
				o_slow_internal_osc_en = r.slow_int_en;
				o_slow_external_crystal_en = r.slow_ext_en;
				o_reg_lowpower = lprun_ok || (r.state == ST_LPSLEEP);
			end
			ST_STOP: begin
				// core clocks and fast oscillators off
				o_reg_lowpower = 1'b1;
			end
			ST_STANDBY: begin
				o_reg_off = 1'b1;
			end
			ST_WAKE: begin
				// oscillator restart; cpu held until the count ends
				o_multi_speed_internal_osc_en = 1'b1;
				o_slow_internal_osc_en = r.slow_int_en;
				o_slow_external_crystal_en = r.slow_ext_en;
			end
			default: begin
				o_reg_off = 1'b0;
			end
		endcase
		o_core_reset = r.core_reset;
	end

	// next state
	always_comb begin
		nxt = r;
		nxt.core_reset = 1'b0;
		nxt.wpin_prev = i_wakeup_pin;
		case (r.state)
			ST_RUN: begin
				// sleep request picks the configured mode
				if (i_sleep_req) begin
					case (r.mode_sel)
						LPMC_MODE_LPSLEEP: nxt.state = ST_LPSLEEP;
						LPMC_MODE_STOP_RTC, LPMC_MODE_STOP_NORTC: nxt.state = ST_STOP;
						LPMC_MODE_STBY_RTC, LPMC_MODE_STBY_NORTC: nxt.state = ST_STANDBY;
						default: nxt.state = ST_SLEEP;
					endcase
				end
			end
			ST_SLEEP, ST_LPSLEEP: begin
				if (wake_sleep) begin
					nxt.state = ST_RUN;
					nxt.cause = src;
					// back to run with regulator fully on
					if (r.state == ST_LPSLEEP) begin
						nxt.lprun_req = 1'b0;
					end
				end
			end
			ST_STOP: begin
				if (wake_stop) begin
					nxt.state = ST_WAKE;
					nxt.cnt = LPMC_STOP_WAIT;
					nxt.stby_path = 1'b0;
					nxt.cause = src;
				end
			end
			ST_STANDBY: begin
				if (wake_stby) begin
					nxt.state = ST_WAKE;
					nxt.cnt = LPMC_STBY_WAIT;
					nxt.stby_path = 1'b1;
					nxt.cause = src;
				end
			end
			ST_WAKE: begin
				if (r.cnt != '0) begin
					nxt.cnt = r.cnt - 10'h001;
				end else begin
					nxt.state = ST_RUN;
					if (r.stby_path) begin
						nxt.core_reset = 1'b1;
						nxt.vrange = LPMC_VRANGE_RST;
						nxt.mode_sel = LPMC_MODE_SLEEP;
						nxt.lprun_req = 1'b0;
						nxt.clk_sel = LPMC_CLK_MSI;
						nxt.msi_range = '0;
						nxt.pll_en = 1'b0;
						nxt.fast_int_en = 1'b0;
						nxt.fast_ext_en = 1'b0;
						nxt.req_khz = LPMC_REQ_KHZ_RST;
						nxt.irq_en = '0;
					end
				end
			end
			default: nxt.state = ST_RUN;
		endcase
		// register access
		if (setup) begin
			case (i_paddr)
				LPMC_OFS_CTRL: nxt.prdata = {24'h0, r.slow_ext_en, r.slow_int_en, r.lprun_req, r.mode_sel, r.vrange};
				LPMC_OFS_CLKCFG: nxt.prdata = {r.req_khz, 8'h0, r.fast_ext_en, r.fast_int_en, r.pll_en,
					r.msi_range, r.clk_sel};
				LPMC_OFS_STATUS: nxt.prdata = {o_cpu_freq_khz, 10'h0, o_sysclk_sel, lprun_ok, r.state};
				LPMC_OFS_CAUSE: nxt.prdata = {23'h0, r.cause};
				LPMC_OFS_IRQ_STAT: nxt.prdata = {29'h0, r.irq_stat};
				LPMC_OFS_IRQ_EN: nxt.prdata = {29'h0, r.irq_en};
				default: nxt.prdata = '0;
			endcase
		end
		if (acc && i_pwrite) begin
			case (i_paddr)
				LPMC_OFS_CTRL: begin
					// range 0 is not a range; keep the old one
					if (i_pwdata[1:0] != 2'h0) begin
						nxt.vrange = i_pwdata[1:0];
					end
					nxt.mode_sel = i_pwdata[4:2];
					nxt.lprun_req = i_pwdata[5];
					nxt.slow_int_en = i_pwdata[6];
					nxt.slow_ext_en = i_pwdata[7];
				end
				LPMC_OFS_CLKCFG: begin
					nxt.clk_sel = i_pwdata[1:0];
					nxt.msi_range = i_pwdata[4:2];
					nxt.pll_en = i_pwdata[5];
					nxt.fast_int_en = i_pwdata[6];
					nxt.fast_ext_en = i_pwdata[7];
					nxt.req_khz = i_pwdata[31:16];
				end
				LPMC_OFS_IRQ_CLR: nxt.irq_stat = r.irq_stat & ~i_pwdata[2:0];
				LPMC_OFS_IRQ_EN: nxt.irq_en = i_pwdata[2:0];
				default: nxt.irq_en = nxt.irq_en;
			endcase
		end
		// sticky events after the clear, so a set wins
		if ((r.state == ST_WAKE && r.cnt == '0) || ((r.state == ST_SLEEP || r.state == ST_LPSLEEP) && wake_sleep)) begin
			nxt.irq_stat[LPMC_IRQ_WAKE] = 1'b1;
		end
		if (r.core_reset) begin
			nxt.irq_stat[LPMC_IRQ_STBY] = 1'b1;
		end
		if ((r.req_khz > cap_khz) || (r.lprun_req && !lprun_ok)) begin
			nxt.irq_stat[LPMC_IRQ_CLAMP] = 1'b1;
		end
		if (i_rst) begin
			nxt = '0;
			nxt.state = ST_RUN;
			nxt.vrange = LPMC_VRANGE_RST;
			nxt.req_khz = LPMC_REQ_KHZ_RST;
			nxt.wpin_prev = '0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		r <= nxt;
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	AST_FREQ_CAP: assert property (o_cpu_freq_khz <= ((r.vrange == 2'h2) ? 16'd16000 :
		(r.vrange == 2'h3) ? 16'd4000 : 16'd32000)) else $error("cpu clock above range cap");
	AST_R3_MSI: assert property (r.vrange == 2'h3 |-> o_sysclk_sel == LPMC_CLK_MSI && !o_pll_en)
		else $error("range three not on msi");
	AST_SLEEP_CLK: assert property (r.state == ST_SLEEP |-> !o_cpu_clk_en && o_periph_clk_en)
		else $error("sleep gating wrong");
	AST_LPRUN: assert property (o_lprun_active |-> o_cpu_freq_khz <= 16'd131 && o_reg_lowpower &&
		r.msi_range <= 3'h1) else $error("low-power run conditions broken");
	AST_LPSLEEP_WAKE: assert property (r.state == ST_LPSLEEP && wake_sleep |=>
		r.state == ST_RUN && !o_reg_lowpower) else $error("low-power sleep wake wrong");
	AST_STOP_OFF: assert property (r.state == ST_STOP |-> !o_pll_en && !o_multi_speed_internal_osc_en &&
		!o_fast_internal_osc_en && !o_fast_external_crystal_en && !o_periph_clk_en && o_reg_lowpower)
		else $error("stop left a clock on");
	AST_STOP_EXIT: assert property (r.state == ST_STOP && wake_stop |-> ##[1:80] r.state == ST_RUN)
		else $error("stop exit too slow");
	AST_STOP_NORTC: assert property (r.state == ST_STOP && r.mode_sel == LPMC_MODE_STOP_NORTC &&
		!(|src[LPMC_WC_USB:LPMC_WC_EXTERNAL_INTERRUPT_LINE]) |-> !o_slow_internal_osc_en && !o_slow_external_crystal_en ##1
		r.state == ST_STOP) else $error("stop without rtc kept slow clock or woke on rtc");
	AST_STBY_REG: assert property (r.state == ST_STANDBY |-> o_reg_off && !o_cpu_clk_en &&
		!o_multi_speed_internal_osc_en) else $error("standby regulator on");
	AST_STBY_RESET: assert property (r.state == ST_STANDBY && wake_stby |-> ##[1:600] o_core_reset)
		else $error("no core reset after standby");
	AST_STBY_EXIT: assert property (r.state == ST_STANDBY && wake_stby |-> ##[1:600] r.state == ST_RUN)
		else $error("standby exit too slow");
	AST_RTC_KEEP: assert property (r.state inside {ST_STOP, ST_STANDBY} && rtc_mode && r.slow_ext_en |->
		o_slow_external_crystal_en) else $error("slow crystal halted");
	AST_SLEEP_ENTRY: assert property (r.state == ST_RUN && i_sleep_req && r.mode_sel == LPMC_MODE_STOP_RTC |=>
		r.state == ST_STOP) else $error("mode select ignored");

	COV_SLEEP: cover property (r.state == ST_SLEEP ##1 r.state == ST_RUN);
	COV_STOP: cover property (r.state == ST_STOP ##1 r.state == ST_WAKE);
	COV_STBY: cover property (o_core_reset);
	COV_LPRUN: cover property (o_lprun_active);
endmodule : lpmc_top

// ==== verif/lpmc_wake_src.sv ====
// lpmc_wake_src: wakeup pins, reset pin and on-chip wake sources facing the controller.
// assumes the bench changes i_act right after a rising clock edge.
`timescale 1ns/100ps
module lpmc_wake_src (
	// control from the bench
	input wire logic i_clk,
	input wire logic [31:0] i_act,
	// wake sources
	output logic [15:0] o_external_interrupt_line,
	output logic [12:0] o_misc,
	output logic o_rpin_n,
	output logic [2:0] o_wkpin
);
	logic [31:0] act_r = 32'h0;
	// sources launch one edge after the request, like a real synchroniser
	always @(posedge i_clk) begin
		act_r <= i_act;
	end
	assign o_external_interrupt_line = act_r[15:0];
	assign o_misc = act_r[28:16];
	// pin low, edge rise
	// reset pin idles high, wakeup pins idle low so only a real rise counts
	assign o_rpin_n = ~act_r[26];
	assign o_wkpin = act_r[31:29];
endmodule : lpmc_wake_src

// ==== verif/tb_low_power_mode_controller.sv ====
// tb_low_power_mode_controller: self-checking bench for lpmc_top over apb.
// assumes the wake source model in lpmc_wake_src.sv and a 10 MHz clock.
`timescale 1ns/100ps
module tb_low_power_mode_controller;
	import lpmc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_req = 1'b0, err, cr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, act = 32'h0, rd, seed = 32'h4efce2c5, req, cap;
	logic [31:0] cause_q[$];
	int n_fail = 0, total_checks = 0, n;
	logic [15:0] external_interrupt_line, freq;
	logic [12:0] misc;
	logic [2:0] wkpin;
	logic [1:0] sel;
	logic [31:0] prdata;
	logic rpin_n, pready, pslverr, cpu_en, per_en, pll, multi_speed_internal_osc, fint, fext, sint, sext, reglp, regoff, crst, irq, lpr;
	initial begin
		forever #50 clk = ~clk;
	end
	lpmc_wake_src u_src (.i_clk(clk), .i_act(act), .o_external_interrupt_line(external_interrupt_line), .o_misc(misc), .o_rpin_n(rpin_n), .o_wkpin(wkpin));
	lpmc_top u_dut (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_sleep_req(sleep_req), .i_periph_irq(misc[12]), .i_external_interrupt_line(external_interrupt_line),
		.i_programmable_voltage_detector(misc[0]), .i_comp1_event(misc[1]), .i_comp2_event(misc[2]),
		.i_vref_on(misc[3]), .i_usb_wakeup(misc[4]), .i_rtc_alarm_a(misc[5]), .i_rtc_alarm_b(misc[6]),
		.i_rtc_tamper(misc[7]), .i_rtc_timestamp(misc[8]), .i_rtc_wakeup(misc[9]), .i_reset_pin_n(rpin_n),
		.i_independent_watchdog_reset(misc[11]), .i_wakeup_pin(wkpin), .o_cpu_clk_en(cpu_en),
		.o_periph_clk_en(per_en), .o_pll_en(pll), .o_multi_speed_internal_osc_en(multi_speed_internal_osc),
		.o_fast_internal_osc_en(fint), .o_fast_external_crystal_en(fext), .o_slow_internal_osc_en(sint),
		.o_slow_external_crystal_en(sext), .o_reg_lowpower(reglp), .o_reg_off(regoff), .o_core_reset(crst),
		.o_sysclk_sel(sel), .o_cpu_freq_khz(freq), .o_lprun_active(lpr), .o_irq(irq));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// waits on pready only; the watchdog ends a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb
	task automatic enter(input logic [7:0] ctrl);
		apb(1'b1, LPMC_OFS_CTRL, {24'h0, ctrl});
		@(posedge clk);
		sleep_req <= 1'b1;
		@(posedge clk);
		sleep_req <= 1'b0;
		#1;
	endtask : enter
	// counts edges from the source request, launch edge included, until the cpu clock returns
	task automatic wake(input logic [31:0] v, input logic [31:0] cause);
		cause_q.push_back(cause);
		@(posedge clk);
		act <= v;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (cpu_en !== 1'b1);
		cr = crst;
		@(posedge clk);
		act <= 32'h0;
		apb(1'b0, LPMC_OFS_CAUSE, 32'h0);
		chk(rd, cause_q.pop_front());
	endtask : wake
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize
	initial begin
		#(30000 * 100);
		n_fail++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk({cpu_en, per_en, multi_speed_internal_osc, pll, fint, fext, sint, sext, irq, freq}, {9'h1c0, 16'd4000});
		apb(1'b0, LPMC_OFS_CTRL, 32'h0);
		chk(rd, 32'h2);
		apb(1'b0, LPMC_OFS_CLKCFG, 32'h0);
		chk(rd, 32'h0fa00000);
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("test reset and map done");
		for (int vr = 1; vr <= 3; vr++) begin
			req = rnd() % 40000;
			cap = (vr == 1) ? 32000 : (vr == 2) ? 16000 : 4000;
			apb(1'b1, LPMC_OFS_CTRL, vr);
			apb(1'b1, LPMC_OFS_CLKCFG, {req[15:0], 16'h00e1});
			chk(freq, (req < cap) ? req : cap);
			chk({sel, fint, fext, pll}, (vr == 3) ? 5'b00000 : 5'b01111);
		end
		$display("test voltage ranges done");
		apb(1'b1, LPMC_OFS_CTRL, 32'h22);
		apb(1'b1, LPMC_OFS_CLKCFG, 32'h0fa00004);
		chk({lpr, reglp, freq}, {2'b11, 16'd131});
		apb(1'b1, LPMC_OFS_CLKCFG, 32'h0fa00008);
		chk(lpr, 1'b0);
		apb(1'b1, LPMC_OFS_CTRL, 32'h2);
		apb(1'b1, LPMC_OFS_IRQ_CLR, 32'h7);
		apb(1'b1, LPMC_OFS_IRQ_EN, 32'h1);
		$display("test low-power run done");
		enter(8'h02);
		chk({cpu_en, per_en}, 2'b01);
		wake(32'h1 << 28, 32'h1);
		chk(n, 32'd2);
		chk(irq, 1'b1);
		apb(1'b1, LPMC_OFS_IRQ_EN, 32'h0);
		chk(irq, 1'b0);
		apb(1'b1, LPMC_OFS_IRQ_EN, 32'h1);
		chk(irq, 1'b1);
		apb(1'b1, LPMC_OFS_IRQ_CLR, 32'h1);
		chk(irq, 1'b0);
		enter(8'h06);
		chk({cpu_en, reglp}, 2'b01);
		wake(32'h1 << (rnd() % 16), 32'h2);
		chk(n, 32'd2);
		chk(reglp, 1'b0);
		$display("test sleep modes done");
		enter(8'h4a);
		chk({pll, multi_speed_internal_osc, fint, fext, cpu_en, sint, reglp}, 7'b0000011);
		wake(32'h1 << 21, 32'h20);
		chk(n, LPMC_STOP_EXIT_CYC + 1);
		enter(8'hce);
		chk({sint, sext}, 2'b00);
		@(posedge clk);
		act <= (32'h1 << 21) | (32'h1 << 17);
		repeat (100) @(posedge clk);
		chk(cpu_en, 1'b0);
		wake(32'h1 << 20, 32'h10);
		chk(n, LPMC_STOP_EXIT_CYC + 1);
		$display("test stop modes done");
		enter(8'h92);
		chk({regoff, sext, pll, multi_speed_internal_osc, fint, fext, sint}, 7'b1100000);
		wake(32'h1 << 27, 32'h80);
		chk(n, LPMC_STBY_EXIT_CYC + 1);
		chk(cr, 1'b1);
		apb(1'b0, LPMC_OFS_CTRL, 32'h0);
		chk(rd, 32'h82);
		apb(1'b0, LPMC_OFS_IRQ_STAT, 32'h0);
		chk(rd[1], 1'b1);
		enter(8'h16);
		@(posedge clk);
		act <= 32'h1 << 27;
		repeat (100) @(posedge clk);
		chk({cpu_en, regoff}, 2'b01);
		wake(32'h1 << 29, 32'h100);
		chk(n, LPMC_STBY_EXIT_CYC + 1);
		chk(cr, 1'b1);
		$display("test standby modes done");
		summarize();
	end
endmodule : tb_low_power_mode_controller
